//--- core/torque_cmd_pkg.sv
// constants, encodings and timing for the torque command select block
package torque_cmd_pkg;

    localparam int         TORQUE_W      = 16;
    localparam int         FRAC_W        = 16;
    localparam int         SYNC_STAGES   = 3;

    localparam logic [1:0] SRC_ANALOG    = 2'h0;
    localparam logic [1:0] SRC_PRESET    = 2'h1;
    localparam logic [1:0] SRC_MIXED     = 2'h2;
    localparam logic [1:0] SRC_RESET     = SRC_ANALOG;

    localparam logic [1:0] SEL_P1        = 2'h0;
    localparam logic [1:0] SEL_P2        = 2'h1;
    localparam logic [1:0] SEL_P3        = 2'h2;
    localparam logic [1:0] SEL_P4        = 2'h3;

    localparam logic [1:0] LIM_BOTH      = 2'h0;
    localparam logic [1:0] LIM_REV_ONLY  = 2'h1;
    localparam logic [1:0] LIM_FWD_ONLY  = 2'h2;
    localparam logic [1:0] LIM_NONE      = 2'h3;
    localparam logic [1:0] LIM_RESET     = LIM_NONE;

    localparam logic [8:0] TC_MIN        = 9'h001;
    localparam logic [8:0] TC_MAX        = 9'h1f4;
    localparam logic [8:0] TC_RESET      = 9'h019;
    localparam int         TC_UNIT_NS    = 100000;
    localparam int         CLK_PERIOD_NS = 8;
    localparam int         TC_UNIT_CYCLES = TC_UNIT_NS / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        OT_CLEAR = 4'h1,
        OT_FWD   = 4'h2,
        OT_REV   = 4'h4,
        OT_BOTH  = 4'h8
    } ot_state_t;

endpackage

//--- core/input_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module input_sync
    import torque_cmd_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [SYNC_STAGES-1:0] chain [W];

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    chain[i] <= '0;
                    dout[i]  <= 1'b0;
                end else if (ce) begin
                    chain[i] <= {chain[i][SYNC_STAGES-2:0], din[i]};
                    if (chain[i][1] == chain[i][2]) begin
                        dout[i] <= chain[i][2];
                    end
                end
            end
        end
    endgenerate
endmodule

//--- core/torque_lpf.sv
// first-order low-pass filter stepped once per time unit
`timescale 1ns/1ps
module torque_lpf
    import torque_cmd_pkg::*;
(
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire logic                       tick,
    input  wire logic [8:0]                 tc,
    input  wire logic signed [TORQUE_W-1:0] din,
    output logic signed [TORQUE_W-1:0]      dout
);
    localparam int ACC_W = TORQUE_W + FRAC_W;

    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W:0]   err;
    logic signed [ACC_W:0]   step;

    // the step never overshoots the target, so the sum cannot overflow
    always_comb begin
        err  = (ACC_W+1)'(signed'({din, FRAC_W'(0)})) - (ACC_W+1)'(acc);
        step = err / $signed({(ACC_W-8)'(0), tc});
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            acc <= '0;
        end else if (ce && tick) begin
            acc <= ACC_W'((ACC_W+1)'(acc) + step);
        end
    end

    assign dout = acc[ACC_W-1:FRAC_W];
endmodule

//--- core/torque_cmd_select.sv
// torque command source selection, modifiers, filter and over-travel lockout
`timescale 1ns/1ps
module torque_cmd_select
    import torque_cmd_pkg::*;
#(
    parameter int UNIT_CYCLES = TC_UNIT_CYCLES
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire logic [1:0]                 torque_source,
    input  wire logic [8:0]                 filter_time_const,
    input  wire logic [1:0]                 limit_enable_digit,
    input  wire logic                       torque_select_bit0,
    input  wire logic                       torque_select_bit1,
    input  wire logic                       command_zero_input,
    input  wire logic                       command_invert_input,
    input  wire logic                       forward_limit_input,
    input  wire logic                       reverse_limit_input,
    input  wire logic signed [TORQUE_W-1:0] analog_command_input,
    input  wire logic signed [TORQUE_W-1:0] torque_preset_1,
    input  wire logic signed [TORQUE_W-1:0] torque_preset_2,
    input  wire logic signed [TORQUE_W-1:0] torque_preset_3,
    input  wire logic signed [TORQUE_W-1:0] torque_preset_4,
    output logic signed [TORQUE_W-1:0]      torque_command,
    output logic                            analog_selected,
    output logic                            forward_overtravel,
    output logic                            reverse_overtravel,
    output logic                            overtravel_stop
);
    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    logic [5:0] pins;
    logic       sel_b0;
    logic       sel_b1;
    logic       zero_on;
    logic       inv_on;
    logic       fwd_closed;
    logic       rev_closed;

    input_sync #(
        .W (6)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .din     ({reverse_limit_input, forward_limit_input,
                   command_invert_input, command_zero_input,
                   torque_select_bit1, torque_select_bit0}),
        .dout    (pins)
    );

    // a pin at 1 is the on state
    assign sel_b0     = pins[0];
    assign sel_b1     = pins[1];
    assign zero_on    = pins[2];
    assign inv_on     = pins[3];
    // switches read 1 while closed inside the safe range
    assign fwd_closed = pins[4];
    assign rev_closed = pins[5];

    // ****************************************************************
    // configuration
    // ****************************************************************
    logic [1:0] src;
    logic [8:0] tc;
    logic [1:0] lim_mode;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            src <= SRC_RESET;
        end else if (ce) begin
            src <= torque_source;
        end
    end

    // zero falls back to the default, anything past the top is held at the top
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tc <= TC_RESET;
        end else if (ce) begin
            if (filter_time_const < TC_MIN) begin
                tc <= TC_RESET;
            end else if (filter_time_const > TC_MAX) begin
                tc <= TC_MAX;
            end else begin
                tc <= filter_time_const;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lim_mode <= LIM_RESET;
        end else if (ce) begin
            lim_mode <= limit_enable_digit;
        end
    end

    // ****************************************************************
    // source selection
    // ****************************************************************
    logic [1:0]                 sel;
    logic signed [TORQUE_W-1:0] preset;
    logic signed [TORQUE_W-1:0] sel_cmd;
    logic                       use_analog;

    assign sel = {sel_b1, sel_b0};

    always_comb begin
        case (sel)
            SEL_P1:  preset = torque_preset_1;
            SEL_P2:  preset = torque_preset_2;
            SEL_P3:  preset = torque_preset_3;
            SEL_P4:  preset = torque_preset_4;
            default: preset = torque_preset_1;
        endcase
    end

    // an undefined source setting is treated as analog, the safest reading
    always_comb begin
        case (src)
            SRC_ANALOG: use_analog = 1'b1;
            SRC_PRESET: use_analog = 1'b0;
            SRC_MIXED:  use_analog = (sel == SEL_P1);
            default:    use_analog = 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sel_cmd         <= '0;
            analog_selected <= 1'b0;
        end else if (ce) begin
            sel_cmd         <= use_analog ? analog_command_input : preset;
            analog_selected <= use_analog;
        end
    end

    // ****************************************************************
    // zero and invert
    // ****************************************************************
    logic signed [TORQUE_W-1:0] mod_cmd;
    logic signed [TORQUE_W-1:0] neg_cmd;

    // the most negative value has no mirror, so it saturates
    assign neg_cmd = (sel_cmd == {1'b1, {(TORQUE_W-1){1'b0}}})
                   ? {1'b0, {(TORQUE_W-1){1'b1}}}
                   : TORQUE_W'(-sel_cmd);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mod_cmd <= '0;
        end else if (ce) begin
            if (zero_on) begin
                mod_cmd <= '0;
            end else if (inv_on) begin
                mod_cmd <= neg_cmd;
            end else begin
                mod_cmd <= sel_cmd;
            end
        end
    end

    // ****************************************************************
    // low-pass filter
    // ****************************************************************
    logic [15:0]                unit_cnt;
    logic                       tick;
    logic signed [TORQUE_W-1:0] filt_cmd;

    assign tick = (unit_cnt == 16'(UNIT_CYCLES - 1));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            unit_cnt <= '0;
        end else if (ce) begin
            unit_cnt <= tick ? '0 : unit_cnt + 16'h0001;
        end
    end

    torque_lpf u_lpf (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .tick    (tick),
        .tc      (tc),
        .din     (mod_cmd),
        .dout    (filt_cmd)
    );

    // ****************************************************************
    // over-travel lockout
    // ****************************************************************
    ot_state_t ot_state;
    ot_state_t next_ot_state;
    logic      fwd_used;
    logic      rev_used;
    logic      fwd_hit;
    logic      rev_hit;
    logic      fwd_lock;
    logic      rev_lock;

    assign fwd_used = (lim_mode == LIM_BOTH) || (lim_mode == LIM_FWD_ONLY);
    assign rev_used = (lim_mode == LIM_BOTH) || (lim_mode == LIM_REV_ONLY);
    // an ignored limit is never looked at, so it may be left unwired
    assign fwd_hit  = fwd_used && !fwd_closed;
    assign rev_hit  = rev_used && !rev_closed;

    always_comb begin
        case ({fwd_hit, rev_hit})
            2'h2:    next_ot_state = OT_FWD;
            2'h1:    next_ot_state = OT_REV;
            2'h3:    next_ot_state = OT_BOTH;
            default: next_ot_state = OT_CLEAR;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ot_state <= OT_CLEAR;
        end else if (ce) begin
            ot_state <= next_ot_state;
        end
    end

    always_comb begin
        case (ot_state)
            OT_FWD: begin
                fwd_lock = 1'b1;
                rev_lock = 1'b0;
            end
            OT_REV: begin
                fwd_lock = 1'b0;
                rev_lock = 1'b1;
            end
            OT_BOTH: begin
                fwd_lock = 1'b1;
                rev_lock = 1'b1;
            end
            default: begin
                fwd_lock = 1'b0;
                rev_lock = 1'b0;
            end
        endcase
    end

    // the clamp sits after the filter so a stop is not smoothed away;
    // the opposite direction still passes so the axis can back out
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            torque_command <= '0;
        end else if (ce) begin
            if ((fwd_lock && filt_cmd > 0) || (rev_lock && filt_cmd < 0)) begin
                torque_command <= '0;
            end else begin
                torque_command <= filt_cmd;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            forward_overtravel <= 1'b0;
            reverse_overtravel <= 1'b0;
            overtravel_stop    <= 1'b0;
        end else if (ce) begin
            forward_overtravel <= fwd_lock;
            reverse_overtravel <= rev_lock;
            overtravel_stop    <= fwd_lock || rev_lock;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_analog_src;
        ce && src == SRC_ANALOG |=> sel_cmd == $past(analog_command_input);
    endproperty
    a_analog_src: assert property (p_analog_src) else $error("analog source not taken");

    property p_preset_src;
        ce && src == SRC_PRESET && sel == SEL_P1 |=> sel_cmd == $past(torque_preset_1);
    endproperty
    a_preset_src: assert property (p_preset_src) else $error("preset 1 not taken");

    property p_mixed_analog;
        ce && src == SRC_MIXED && sel == SEL_P1 |=> analog_selected;
    endproperty
    a_mixed_analog: assert property (p_mixed_analog) else $error("mixed analog missed");

    property p_mixed_preset;
        ce && src == SRC_MIXED && sel == SEL_P3 |=> sel_cmd == $past(torque_preset_3);
    endproperty
    a_mixed_preset: assert property (p_mixed_preset) else $error("mixed preset 3 missed");

    property p_sel_on;
        ce && src == SRC_MIXED && sel_b0 |=> !analog_selected;
    endproperty
    a_sel_on: assert property (p_sel_on) else $error("select bit on ignored");

    property p_zero;
        ce && zero_on |=> mod_cmd == 0;
    endproperty
    a_zero: assert property (p_zero) else $error("command not forced to zero");

    property p_invert;
        ce && !zero_on && inv_on && sel_cmd != {1'b1, {(TORQUE_W-1){1'b0}}}
            |=> mod_cmd == TORQUE_W'(-$past(sel_cmd));
    endproperty
    a_invert: assert property (p_invert) else $error("command not inverted");

    property p_tc_range;
        tc >= TC_MIN && tc <= TC_MAX;
    endproperty
    a_tc_range: assert property (p_tc_range) else $error("filter constant out of range");

    property p_fwd_block;
        ce && fwd_lock && filt_cmd > 0 |=> torque_command == 0 && overtravel_stop;
    endproperty
    a_fwd_block: assert property (p_fwd_block) else $error("forward drive not blocked");

    property p_ignored;
        ce && lim_mode == LIM_NONE |=> ot_state == OT_CLEAR;
    endproperty
    a_ignored: assert property (p_ignored) else $error("ignored limit acted");

    property p_back_out;
        ce && ot_state == OT_FWD && filt_cmd < 0 |=> torque_command == $past(filt_cmd);
    endproperty
    a_back_out: assert property (p_back_out) else $error("reverse exit refused");

    property p_zero_wins;
        ce && zero_on && inv_on && sel_cmd != 0 |=> mod_cmd == 0;
    endproperty
    a_zero_wins: assert property (p_zero_wins) else $error("invert beat zero");
endmodule

//--- sim/host_model.sv
// host controller model driving the digital command and limit pins
`timescale 1ns/1ps
module host_model
    import torque_cmd_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [1:0] limit_enable_digit,
    output logic            torque_select_bit0,
    output logic            torque_select_bit1,
    output logic            command_zero_input,
    output logic            command_invert_input,
    output logic            forward_limit_input,
    output logic            reverse_limit_input
);
    import torque_cmd_pkg::*;

    logic fwd_q;
    logic rev_q;
    logic fwd_used;
    logic rev_used;

    assign fwd_used = (limit_enable_digit == LIM_BOTH) || (limit_enable_digit == LIM_FWD_ONLY);
    assign rev_used = (limit_enable_digit == LIM_BOTH) || (limit_enable_digit == LIM_REV_ONLY);

    initial begin
        {torque_select_bit1, torque_select_bit0} = 2'h0;
        command_zero_input   = 1'b0;
        command_invert_input = 1'b0;
        forward_limit_input  = 1'b1;
        reverse_limit_input  = 1'b1;
        fwd_q                = 1'b1;
        rev_q                = 1'b1;
    end

    task automatic set_cmd(input logic b1, input logic b0, input logic z, input logic i);
        torque_select_bit1   = b1;
        torque_select_bit0   = b0;
        command_zero_input   = z;
        command_invert_input = i;
    endtask

    task automatic set_limits(input logic f, input logic r);
        fwd_q = f;
        rev_q = r;
    endtask

    // ************************************************
    // limit wiring
    // ************************************************
    // closed contact (1) is the safe range; an ignored limit is left unwired, so it wanders
    always @(posedge ref_clk) begin
        #1;
        forward_limit_input <= fwd_used ? fwd_q : ~forward_limit_input;
        reverse_limit_input <= rev_used ? rev_q : ~reverse_limit_input;
    end
endmodule

//--- sim/torque_cmd_select_test.sv
// self-checking bench for the torque command select block
`timescale 1ns/1ps
module torque_cmd_select_test;
    import torque_cmd_pkg::*;

    typedef struct packed {
        logic signed [TORQUE_W-1:0] cmd;
        logic                       ana;
        logic                       fwd;
        logic                       rev;
    } note_t;

    localparam int UNIT   = 4;
    localparam int SETTLE = 16;

    logic                       ref_clk;
    logic                       rst_n;
    logic                       ce;
    logic [1:0]                 src;
    logic [1:0]                 dig;
    logic [8:0]                 tc;
    logic                       s0;
    logic                       s1;
    logic                       zr;
    logic                       iv;
    logic                       fl;
    logic                       rl;
    logic signed [TORQUE_W-1:0] ana;
    logic signed [TORQUE_W-1:0] p1;
    logic signed [TORQUE_W-1:0] p2;
    logic signed [TORQUE_W-1:0] p3;
    logic signed [TORQUE_W-1:0] p4;
    logic signed [TORQUE_W-1:0] tcmd;
    logic                       ana_sel;
    logic                       fot;
    logic                       rot;
    logic                       ots;
    logic [1:0]                 b_sel;
    logic                       b_zr;
    logic                       b_iv;
    logic                       b_fl;
    logic                       b_rl;
    logic [31:0]                lfsr_state;
    note_t                      exp_q[$];
    note_t                      got;
    note_t                      frozen;
    event                       check_ev;
    int                         miscompares;
    int                         num_checks;
    int                         cycles;

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    host_model i_host_model (
        .ref_clk              (ref_clk),
        .limit_enable_digit   (dig),
        .torque_select_bit0   (s0),
        .torque_select_bit1   (s1),
        .command_zero_input   (zr),
        .command_invert_input (iv),
        .forward_limit_input  (fl),
        .reverse_limit_input  (rl)
    );

    torque_cmd_select #(.UNIT_CYCLES(UNIT)) i_torque_cmd_select (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .ce                   (ce),
        .torque_source        (src),
        .filter_time_const    (tc),
        .limit_enable_digit   (dig),
        .torque_select_bit0   (s0),
        .torque_select_bit1   (s1),
        .command_zero_input   (zr),
        .command_invert_input (iv),
        .forward_limit_input  (fl),
        .reverse_limit_input  (rl),
        .analog_command_input (ana),
        .torque_preset_1      (p1),
        .torque_preset_2      (p2),
        .torque_preset_3      (p3),
        .torque_preset_4      (p4),
        .torque_command       (tcmd),
        .analog_selected      (ana_sel),
        .forward_overtravel   (fot),
        .reverse_overtravel   (rot),
        .overtravel_stop      (ots)
    );

    // ************************************************
    // helpers
    // ************************************************
    // odd and never zero, so a clamp to zero always shows
    function automatic logic signed [TORQUE_W-1:0] rnd();
        lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1]
                      ^ lfsr_state[0]};
        return {{3{lfsr_state[13]}}, lfsr_state[12:1], 1'b1};
    endfunction

    task automatic cmp_val(input logic signed [TORQUE_W-1:0] a,
                           input logic signed [TORQUE_W-1:0] e, input string what);
        num_checks++;
        if (a !== e) begin
            $display("Error at %0t: %s is %0d, expected %0d", $time, what, a, e);
            miscompares++;
        end
    endtask

    task automatic cmp_bit(input logic a, input logic e, input string what);
        num_checks++;
        if (a !== e) begin
            $display("Error at %0t: %s is %b, expected %b", $time, what, a, e);
            miscompares++;
        end
    endtask

    function automatic note_t predict();
        note_t                      n;
        logic signed [TORQUE_W-1:0] v;
        logic                       fe;
        logic                       re;
        n.ana = (src == SRC_PRESET) ? 1'b0 : (src == SRC_MIXED) ? (b_sel == SEL_P1) : 1'b1;
        case (b_sel)
            SEL_P1:  v = p1;
            SEL_P2:  v = p2;
            SEL_P3:  v = p3;
            default: v = p4;
        endcase
        if (n.ana) v = ana;
        if (b_iv) v = (v == 16'sh8000) ? 16'sh7fff : -v;
        if (b_zr) v = '0;
        fe = (dig == LIM_BOTH) || (dig == LIM_FWD_ONLY);
        re = (dig == LIM_BOTH) || (dig == LIM_REV_ONLY);
        n.fwd = fe && !b_fl;
        n.rev = re && !b_rl;
        if ((n.fwd && v > 0) || (n.rev && v < 0)) v = '0;
        n.cmd = v;
        return n;
    endfunction

    // sets the pins, lets sync, filter tick and output stage settle, then notes the result
    task automatic go(input logic [1:0] s, input logic [1:0] sel, input logic z, input logic i);
        src   = s;
        b_sel = sel;
        b_zr  = z;
        b_iv  = i;
        i_host_model.set_cmd(sel[1], sel[0], z, i);
        i_host_model.set_limits(b_fl, b_rl);
        repeat (SETTLE) @(posedge ref_clk);
        #1;
        exp_q.push_back(predict());
        ->check_ev;
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic end_sim();
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ************************************************
    // result watcher
    // ************************************************
    always @(check_ev) begin
        got = exp_q.pop_front();
        cmp_val(tcmd, got.cmd, "torque command");
        cmp_bit(ana_sel, got.ana, "analog selected");
        cmp_bit(fot, got.fwd, "forward lockout");
        cmp_bit(rot, got.rev, "reverse lockout");
        cmp_bit(ots, got.fwd | got.rev, "overtravel stop");
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            $display("Error at %0t: run did not finish in time", $time);
            end_sim();
        end
    end

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        miscompares = 0;
        num_checks  = 0;
        cycles      = 0;
        lfsr_state  = 32'hbaa7;
        rst_n = 1'b0;
        ce    = 1'b1;
        src   = SRC_ANALOG;
        dig   = LIM_NONE;
        tc    = 9'h001;
        b_fl  = 1'b1;
        b_rl  = 1'b1;
        ana = rnd();
        p1  = rnd();
        p2  = rnd();
        p3  = rnd();
        p4  = rnd();
        repeat (5) @(posedge ref_clk);
        #1;
        cmp_val(tcmd, 16'sh0000, "reset torque");
        cmp_bit(ots, 1'b0, "reset stop");
        rst_n = 1'b1;
        go(SRC_ANALOG, 2'h0, 1'b0, 1'b0);
        go(SRC_ANALOG, 2'h3, 1'b0, 1'b0);
        go(2'h3, 2'h2, 1'b0, 1'b0);
        done("analog source");
        // with the clock enable low nothing may move, not even the analog path
        frozen = predict();
        ce     = 1'b0;
        ana    = ~ana;
        repeat (SETTLE) @(posedge ref_clk);
        #1;
        cmp_val(tcmd, frozen.cmd, "frozen torque");
        cmp_bit(ana_sel, frozen.ana, "frozen analog selected");
        ce     = 1'b1;
        done("clock enable");
        for (int k = 0; k < 4; k++) go(SRC_PRESET, k[1:0], 1'b0, 1'b0);
        for (int k = 3; k >= 0; k--) go(SRC_MIXED, k[1:0], 1'b0, 1'b0);
        done("preset and mixed sources");
        go(SRC_PRESET, 2'h1, 1'b1, 1'b0);
        go(SRC_MIXED, 2'h2, 1'b0, 1'b1);
        go(SRC_ANALOG, 2'h0, 1'b1, 1'b1);
        done("zero and invert");
        p1 = 16'sh1234;
        p2 = 16'shfa99;
        for (int d = 0; d < 4; d++) begin
            dig  = d[1:0];
            b_fl = 1'b0;
            b_rl = 1'b0;
            go(SRC_PRESET, 2'h0, 1'b0, 1'b0);
            go(SRC_PRESET, 2'h1, 1'b0, 1'b0);
            b_fl = 1'b1;
            go(SRC_PRESET, 2'h1, 1'b0, 1'b0);
            go(SRC_PRESET, 2'h0, 1'b0, 1'b0);
        end
        done("over-travel");
        dig = LIM_NONE;
        go(SRC_PRESET, 2'h0, 1'b1, 1'b0);
        tc = TC_MAX;
        i_host_model.set_cmd(1'b0, 1'b0, 1'b0, 1'b0);
        repeat (SETTLE) @(posedge ref_clk);
        #1;
        cmp_bit(tcmd > 16'sh0000 && tcmd < 16'sh0200, 1'b1, "slow filter output");
        done("filter");
        end_sim();
    end
endmodule
